// file: design/dirc_regs.svh
// constants of the converter input register and decoder
`ifndef DIRC_REGS_SVH
`define DIRC_REGS_SVH

// ********************************************************************
// widths
// ********************************************************************
`define DIRC_CODE_W        12
`define DIRC_UPPER_W       4
`define DIRC_THERM_W       15
`define DIRC_UBIN_W        2
`define DIRC_MBIN_W        3
`define DIRC_LBIN_W        3

// ********************************************************************
// field positions inside a sample code
// ********************************************************************
`define DIRC_UPPER_MSB     11
`define DIRC_UPPER_LSB     8
`define DIRC_UBIN_MSB      7
`define DIRC_UBIN_LSB      6
`define DIRC_MBIN_MSB      5
`define DIRC_MBIN_LSB      3
`define DIRC_LBIN_MSB      2
`define DIRC_LBIN_LSB      0

// ********************************************************************
// group weights in code steps
// ********************************************************************
`define DIRC_THERM_WEIGHT  256
`define DIRC_UBIN_WEIGHT   64
`define DIRC_MBIN_WEIGHT   8
`define DIRC_LBIN_WEIGHT   1

// ********************************************************************
// reset values
// ********************************************************************
`define DIRC_CODE_RST      12'h000
`define DIRC_LEVEL_RST     12'h000
`define DIRC_COMP_RST      12'hFFF
`define DIRC_THERM_RST     15'h0000

// ********************************************************************
// timing
// ********************************************************************
`define DIRC_REF_CLK_KHZ   25000
`define DIRC_MSB_DECODE_PS 900
`define DIRC_MSB_LAG_RAW   ((`DIRC_MSB_DECODE_PS * `DIRC_REF_CLK_KHZ \
                             + 999999999) / 1000000000)
`define DIRC_MSB_LAG_CYC   ((`DIRC_MSB_LAG_RAW < 1) ? 1 : `DIRC_MSB_LAG_RAW)

`endif

// file: design/dirc_pkg.sv
// types of the converter input register and decoder
`include "dirc_regs.svh"

package dirc_pkg;

    typedef logic [`DIRC_CODE_W-1:0] dirc_code_type;

    typedef struct packed {
        logic [`DIRC_THERM_W-1:0] therm;
        logic [`DIRC_UBIN_W-1:0]  upper_bin;
        logic [`DIRC_MBIN_W-1:0]  mid_bin;
        logic [`DIRC_LBIN_W-1:0]  low_bin;
    } dirc_ctrl_type;

endpackage : dirc_pkg

// file: design/dirc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps

module dirc_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         resetn,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_ff;

    // ****************************************************************
    // two stages
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            meta_ff  <= '0;
            sync_out <= '0;
        end else begin
            meta_ff  <= pin_in;
            sync_out <= meta_ff;
        end
    end

endmodule : dirc_sync

// file: design/dirc_therm_dec.sv
// four-bit to fifteen-line thermometer decoder
`timescale 1ns/100ps
`include "dirc_regs.svh"

module dirc_therm_dec
    import dirc_pkg::*;
(
    input  wire logic [`DIRC_UPPER_W-1:0] upper_code_bits,
    output logic      [`DIRC_THERM_W-1:0] therm
);

    // ****************************************************************
    // line i is on when the value exceeds i
    // ****************************************************************
    always_comb begin
        for (int i = 0; i < `DIRC_THERM_W; i++) begin
            therm[i] = ({1'b0, upper_code_bits} > 5'(i));
        end
    end

endmodule : dirc_therm_dec

// file: design/dirc_top.sv
// master/slave input register and switch decoder of the converter
`timescale 1ns/100ps
`include "dirc_regs.svh"

// Notes on behaviour
// - transparent select high disables data latching
// - clocked mode updates only on rising clock
// - clock low: master follows, slave holds
// - rising edge freezes master, copies to slave
// - transparent mode passes data regardless of clock
// - registered stage before every switch control
// - four upper bits become fifteen-line thermometer
// - upper six bits drive seventeen full-weight controls
// - bits five to three weigh one eighth
// - bits two to zero weigh one sixtyfourth
// - straight binary, complementary outputs move oppositely
// - transparent mode: upper bits arrive late
module dirc_top
    import dirc_pkg::*;
(
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    input  wire dirc_pkg::dirc_code_type  sample_code_bits,
    input  wire logic                     conv_clk,
    input  wire logic                     transparent_sel,
    output dirc_pkg::dirc_ctrl_type       switch_ctrl,
    output dirc_pkg::dirc_code_type       true_analog_output,
    output dirc_pkg::dirc_code_type       comp_analog_output
);

    import dirc_pkg::*;

    localparam int MSB_LAG = `DIRC_MSB_LAG_CYC;

    // ****************************************************************
    // declarations
    // ****************************************************************
    dirc_code_type               code_s;
    logic                        conv_clk_s;
    logic                        bypass_s;
    logic                        conv_clk_prev_ff;
    logic                        clk_rise;
    dirc_code_type               master_ff;
    dirc_code_type               slave_ff;
    logic [`DIRC_THERM_W-1:0]    therm_now;
    logic [`DIRC_THERM_W-1:0]    therm_lag_ff [MSB_LAG];
    dirc_ctrl_type               nxt_ctrl;
    dirc_ctrl_type               ctrl_ff;
    dirc_code_type               level_ff;
    dirc_code_type               comp_ff;

    // ****************************************************************
    // functions
    // ****************************************************************
    function automatic dirc_code_type level_of(input dirc_ctrl_type c);
        int acc;
        acc = $countones(c.therm) * `DIRC_THERM_WEIGHT;
        acc = acc + int'(c.upper_bin) * `DIRC_UBIN_WEIGHT;
        acc = acc + int'(c.mid_bin) * `DIRC_MBIN_WEIGHT;
        acc = acc + int'(c.low_bin) * `DIRC_LBIN_WEIGHT;
        return dirc_code_type'(acc);
    endfunction : level_of

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    dirc_sync #(
        .W (`DIRC_CODE_W + 2)
    ) u_pin_sync (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .pin_in   ({sample_code_bits, conv_clk, transparent_sel}),
        .sync_out ({code_s, conv_clk_s, bypass_s})
    );

    // ****************************************************************
    // converter clock edge
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            conv_clk_prev_ff <= 1'b0;
        end else begin
            conv_clk_prev_ff <= conv_clk_s;
        end
    end

    assign clk_rise = conv_clk_s & ~conv_clk_prev_ff;

    // ****************************************************************
    // master stage
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            master_ff <= `DIRC_CODE_RST;
        end else if (bypass_s) begin
            master_ff <= code_s;
        end else if (!conv_clk_s) begin
            master_ff <= code_s;
        end
        // clock high in clocked mode: master frozen
    end

    // ****************************************************************
    // slave stage
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            slave_ff <= `DIRC_CODE_RST;
        end else if (bypass_s) begin
            slave_ff <= code_s;
        end else if (clk_rise) begin
            slave_ff <= master_ff;
        end
        // otherwise slave holds
    end

    // ****************************************************************
    // upper bit decode and its delay
    // ****************************************************************
    dirc_therm_dec u_therm_dec (
        .upper_code_bits (slave_ff[`DIRC_UPPER_MSB:`DIRC_UPPER_LSB]),
        .therm           (therm_now)
    );

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < MSB_LAG; i++) begin
                therm_lag_ff[i] <= `DIRC_THERM_RST;
            end
        end else begin
            therm_lag_ff[0] <= therm_now;
            for (int i = 1; i < MSB_LAG; i++) begin
                therm_lag_ff[i] <= therm_lag_ff[i-1];
            end
        end
    end

    // ****************************************************************
    // switch controls
    // ****************************************************************
    always_comb begin
        // decoded in time in clocked mode, late in transparent mode
        nxt_ctrl.therm     = bypass_s ? therm_lag_ff[MSB_LAG-1]
                                      : therm_now;
        nxt_ctrl.upper_bin = slave_ff[`DIRC_UBIN_MSB:`DIRC_UBIN_LSB];
        nxt_ctrl.mid_bin   = slave_ff[`DIRC_MBIN_MSB:`DIRC_MBIN_LSB];
        nxt_ctrl.low_bin   = slave_ff[`DIRC_LBIN_MSB:`DIRC_LBIN_LSB];
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_ff <= '0;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign switch_ctrl = ctrl_ff;

    // ****************************************************************
    // output levels
    // ****************************************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            level_ff <= `DIRC_LEVEL_RST;
            comp_ff  <= `DIRC_COMP_RST;
        end else begin
            level_ff <= level_of(nxt_ctrl);
            comp_ff  <= ~level_of(nxt_ctrl);
        end
    end

    assign true_analog_output = level_ff;
    assign comp_analog_output = comp_ff;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking dirc_cb @(posedge ref_clk);
    endclocking

    default disable iff (!resetn);

    sequence s_clocked_low;
        !bypass_s && !conv_clk_s;
    endsequence

    sequence s_rise_clocked;
        !bypass_s && clk_rise;
    endsequence

    sequence s_bypass_steady;
        (bypass_s && $stable(code_s)) [*3];
    endsequence

    sequence s_clocked_quiet;
        (!bypass_s && !clk_rise) [*3];
    endsequence

    sequence s_rise_settle;
        s_rise_clocked ##1 !bypass_s;
    endsequence

    sequence s_upper_step_bypass;
        bypass_s ##1 (bypass_s
            && $changed(slave_ff[`DIRC_UPPER_MSB:`DIRC_UPPER_LSB]));
    endsequence

    a_bypass_no_latch: assert property (
        bypass_s |=> slave_ff == $past(code_s) && master_ff == $past(code_s)
    ) else $error("transparent mode latched stale data");

    a_no_edge_hold: assert property (
        !bypass_s && !clk_rise |=> $stable(slave_ff)
    ) else $error("slave changed without rising clock");

    a_master_follow: assert property (
        s_clocked_low |=> master_ff == $past(code_s)
    ) else $error("master not following while clock low");

    a_master_freeze: assert property (
        !bypass_s && conv_clk_s |=> $stable(master_ff)
    ) else $error("master changed while clock high");

    a_rise_transfer: assert property (
        s_rise_clocked |=> slave_ff == $past(master_ff)
    ) else $error("rising clock did not copy master to slave");

    a_transp_pass: assert property (
        s_bypass_steady |=> true_analog_output == $past(code_s)
    ) else $error("transparent data did not reach output");

    a_switch_together: assert property (
        !bypass_s && $past(!bypass_s) && $past(!bypass_s, 2)
            && $changed(ctrl_ff) |-> $past(clk_rise, 2)
    ) else $error("switch controls moved without a clock edge");

    a_therm_count: assert property (
        $past(!bypass_s) |-> $countones(ctrl_ff.therm)
            == int'($past(slave_ff[`DIRC_UPPER_MSB:`DIRC_UPPER_LSB]))
    ) else $error("thermometer count differs from upper bits");

    a_therm_shape: assert property (
        ((ctrl_ff.therm + 15'h0001) & ctrl_ff.therm) == 15'h0000
    ) else $error("thermometer lines not contiguous");

    a_upper_bin: assert property (
        ##1 ctrl_ff.upper_bin == $past(slave_ff[`DIRC_UBIN_MSB:`DIRC_UBIN_LSB])
    ) else $error("upper binary controls wrong");

    a_mid_bin: assert property (
        ##1 ctrl_ff.mid_bin == $past(slave_ff[`DIRC_MBIN_MSB:`DIRC_MBIN_LSB])
    ) else $error("middle binary controls wrong");

    a_low_bin: assert property (
        ##1 ctrl_ff.low_bin == $past(slave_ff[`DIRC_LBIN_MSB:`DIRC_LBIN_LSB])
    ) else $error("low binary controls wrong");

    a_comp_level: assert property (
        true_analog_output + comp_analog_output == 12'hFFF
    ) else $error("outputs not complementary");

    a_level_map: assert property (
        $past(!bypass_s) && $past(!bypass_s, 2) && $stable(slave_ff)
            |=> true_analog_output == $past(slave_ff)
    ) else $error("level does not match registered code");

    a_msb_late: assert property (
        $past(bypass_s) |-> $countones(ctrl_ff.therm)
            == int'($past(slave_ff[`DIRC_UPPER_MSB:`DIRC_UPPER_LSB], 2))
    ) else $error("upper bits not delayed in transparent mode");

    a_rise_output: assert property (
        s_rise_settle |=> true_analog_output == $past(master_ff, 2)
    ) else $error("output not taken from master at rising clock");

    a_output_stands: assert property (
        s_clocked_quiet |=> $stable(true_analog_output)
            && $stable(switch_ctrl)
    ) else $error("output moved between rising clock edges");

    a_transp_master: assert property (
        bypass_s && conv_clk_s |=> master_ff == $past(code_s)
    ) else $error("transparent master ignored data while clock high");

    a_msb_step_lag: assert property (
        s_upper_step_bypass |=> $countones(ctrl_ff.therm)
            != int'($past(slave_ff[`DIRC_UPPER_MSB:`DIRC_UPPER_LSB]))
    ) else $error("upper bits reached the output without decode lag");

    a_upper_six: assert property (
        true_analog_output[`DIRC_UPPER_MSB:`DIRC_UBIN_LSB]
            == 6'($countones(ctrl_ff.therm) * 4 + int'(ctrl_ff.upper_bin))
    ) else $error("upper six bits do not carry full weight");

    a_level_weights: assert property (
        true_analog_output == {4'($countones(ctrl_ff.therm)),
                               ctrl_ff.upper_bin, ctrl_ff.mid_bin,
                               ctrl_ff.low_bin}
    ) else $error("output level does not weigh the switch controls");

endmodule : dirc_top

// file: tb/dirc_source_model.sv
// parallel sample source that feeds the converter pins
`timescale 1ns/100ps

module dirc_source_model
    import dirc_pkg::*;
(
    input  wire logic             ref_clk,
    output dirc_pkg::dirc_code_type sample_code_bits,
    output logic                  conv_clk,
    output logic                  transparent_sel
);
    import dirc_pkg::*;

    // ********
    // pin drive
    // ********
    initial begin
        sample_code_bits = 12'h000;
        conv_clk         = 1'b0;
        transparent_sel  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // one clocked word: stable while clock low, held past the rise
    task automatic send_word(input dirc_code_type code);
        conv_clk         = 1'b0;
        sample_code_bits = code;
        tick(3);
        conv_clk = 1'b1;
        tick(3);
        conv_clk         = 1'b0;
        sample_code_bits = ~code;
        tick(1);
    endtask : send_word

    task automatic set_code(input dirc_code_type code);
        sample_code_bits = code;
    endtask : set_code

    task automatic set_clk(input logic v);
        conv_clk = v;
    endtask : set_clk

    task automatic set_mode(input logic t);
        transparent_sel = t;
    endtask : set_mode

endmodule : dirc_source_model

// file: tb/dirc_top_bench.sv
// self-checking bench of the converter input register and decoder
`timescale 1ns/100ps

module dirc_top_bench;
    import dirc_pkg::*;

    logic            ref_clk;
    logic            resetn;
    dirc_code_type   sample_code_bits;
    logic            conv_clk;
    logic            transparent_sel;
    dirc_ctrl_type   switch_ctrl;
    dirc_code_type   true_analog_output;
    dirc_code_type   comp_analog_output;
    int              error_cnt;
    int              checks;

    dirc_top dirc_top_i (
        .ref_clk            (ref_clk),
        .resetn             (resetn),
        .sample_code_bits   (sample_code_bits),
        .conv_clk           (conv_clk),
        .transparent_sel    (transparent_sel),
        .switch_ctrl        (switch_ctrl),
        .true_analog_output (true_analog_output),
        .comp_analog_output (comp_analog_output)
    );

    dirc_source_model dirc_source_model_i (
        .ref_clk          (ref_clk),
        .sample_code_bits (sample_code_bits),
        .conv_clk         (conv_clk),
        .transparent_sel  (transparent_sel)
    );

    // ********
    // helpers
    // ********
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : step

    task automatic wait_for(input dirc_code_type code);
        int n;
        n = 0;
        while (true_analog_output !== code && n < 12) begin
            step(1);
            n++;
        end
        if (n >= 12) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: output never settled", $time);
            wrap_up();
        end
        step(1);
    endtask : wait_for

    task automatic check_word(input dirc_code_type code);
        check(true_analog_output, code);
        check(comp_analog_output, 12'hFFF - code);
        check(24'($countones(switch_ctrl.therm)), code[11:8]);
        check(switch_ctrl.upper_bin, code[7:6]);
        check(switch_ctrl.mid_bin, code[5:3]);
        check(switch_ctrl.low_bin, code[2:0]);
    endtask : check_word

    // ********
    // scenarios
    // ********
    task automatic sc_reset;
        resetn = 1'b0;
        step(2);
        check(switch_ctrl, 24'h000000);
        check_word(12'h000);
        resetn = 1'b1;
        step(3);
    endtask : sc_reset

    task automatic sc_clocked_codes;
        dirc_code_type tbl[6] = '{12'h000, 12'hFFF, 12'h800,
                                  12'h7FF, 12'h001, 12'h5A3};
        foreach (tbl[i]) begin
            dirc_source_model_i.send_word(tbl[i]);
            wait_for(tbl[i]);
            check_word(tbl[i]);
        end
    endtask : sc_clocked_codes

    task automatic sc_hold_and_freeze;
        dirc_source_model_i.send_word(12'h123);
        wait_for(12'h123);
        step(8);
        check_word(12'h123);
        dirc_source_model_i.set_clk(1'b1);
        wait_for(12'hEDC);
        check_word(12'hEDC);
        dirc_source_model_i.set_code(12'h456);
        step(8);
        check_word(12'hEDC);
        dirc_source_model_i.set_clk(1'b0);
        step(8);
        check_word(12'hEDC);
    endtask : sc_hold_and_freeze

    task automatic sc_transparent;
        logic mid_seen;
        int   n;
        mid_seen = 1'b0;
        dirc_source_model_i.set_mode(1'b1);
        dirc_source_model_i.set_code(12'h000);
        wait_for(12'h000);
        dirc_source_model_i.set_code(12'hFFF);
        n = 0;
        while (true_analog_output !== 12'hFFF && n < 12) begin
            if (true_analog_output === 12'h0FF) mid_seen = 1'b1;
            step(1);
            n++;
        end
        if (n >= 12) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: full scale never reached", $time);
            wrap_up();
        end
        check(mid_seen, 1'b1);
        check_word(12'hFFF);
        dirc_source_model_i.set_clk(1'b1);
        dirc_source_model_i.set_code(12'h5A3);
        wait_for(12'h5A3);
        check_word(12'h5A3);
        dirc_source_model_i.set_clk(1'b0);
        dirc_source_model_i.set_mode(1'b0);
        step(4);
    endtask : sc_transparent

    // ********
    // main sequence
    // ********
    initial begin
        error_cnt = 0;
        checks    = 0;
        resetn    = 1'b0;
        step(2);
        resetn = 1'b1;
        step(3);
        sc_clocked_codes();
        sc_hold_and_freeze();
        sc_transparent();
        sc_reset();
        sc_clocked_codes();
        wrap_up();
    end

endmodule : dirc_top_bench
